// ---- fbsc_map.vh ----
// Constants for the flyback startup and sensing controller.
// Assumes a 50 MHz core clock; included by bare name.
`ifndef FBSC_MAP_VH
`define FBSC_MAP_VH
`define FBSC_CLK_MHZ 50
`define FBSC_LEB_NS 480
`define FBSC_LEB_CYC ((`FBSC_LEB_NS * `FBSC_CLK_MHZ + 999) / 1000)
`define FBSC_PROBE_LEBS 8
`define FBSC_SS_FREQ_KHZ 20
`define FBSC_SS_PERIOD_CYC (`FBSC_CLK_MHZ * 1000 / `FBSC_SS_FREQ_KHZ)
`define FBSC_STEP_US 500
`define FBSC_STEP_CYC (`FBSC_STEP_US * `FBSC_CLK_MHZ)
`define FBSC_PRESET_HALF_NS 9823000
`define FBSC_PRESET_HALF_CYC (`FBSC_PRESET_HALF_NS / 1000 * `FBSC_CLK_MHZ)
`define FBSC_TIMEOUT_MULT 967
`define FBSC_RING_EVERY 7
`define FBSC_SAMPLE_DIV_SHIFT 6
`define FBSC_DIODE_MV 700
`define FBSC_RESTART_CYC 50000
`define FBSC_GATE_MA_MIN 8'h1E
`define FBSC_GATE_MA_MAX 8'hB4
`endif

// ---- fbsc_timer.v ----
// Down-counting one-shot timer with load and expiry pulse.
// Assumes one synchronous clock with a common enable.
`timescale 1ns/10ps
module fbsc_timer (
   input wire core_clk,
   input wire sys_rst,
   input wire clkEn,
   input wire load,
   input wire [31:0] loadValue,
   output reg running,
   output reg expired
);
   reg [31:0] count_r;
   always @(posedge core_clk) begin
      if (sys_rst) begin
         count_r <= 32'h0;
         running <= 1'b0;
         expired <= 1'b0;
      end else if (clkEn) begin
         expired <= 1'b0;
         if (load) begin
            count_r <= loadValue;
            running <= 1'b1;
         end else if (running) begin
            if (count_r <= 32'h1) begin
               running <= 1'b0;
               expired <= 1'b1;
            end
            count_r <= count_r - 32'h1;
         end
      end
   end
endmodule

// ---- fbsc_half_period.v ----
// Measures the rectified line half-period from line-sense zero edges.
// Assumes lineZero is a clean synchronous level from the line comparator.
`timescale 1ns/10ps
`include "fbsc_map.vh"
module fbsc_half_period (
   input wire core_clk,
   input wire sys_rst,
   input wire clkEn,
   input wire lineZero,
   input wire allowSync,
   output reg [31:0] halfPeriod,
   output reg locked,
   output reg halfTick
);
   reg [31:0] count_r;
   reg [31:0] phase_r;
   reg zeroDly_r;
   wire zeroEdge = lineZero & ~zeroDly_r;
   always @(posedge core_clk) begin
      if (sys_rst) begin
         count_r <= 32'h0;
         phase_r <= 32'h0;
         zeroDly_r <= 1'b0;
         halfPeriod <= `FBSC_PRESET_HALF_CYC;
         locked <= 1'b0;
         halfTick <= 1'b0;
      end else if (clkEn) begin
         zeroDly_r <= lineZero;
         count_r <= count_r + 32'h1;
         halfTick <= 1'b0;
         // Lost lock falls back to the preset period.
         if (!allowSync || count_r > 2 * `FBSC_PRESET_HALF_CYC) begin
            locked <= 1'b0;
            halfPeriod <= `FBSC_PRESET_HALF_CYC;
         end
         if (allowSync && zeroEdge) begin
            count_r <= 32'h0;
            halfPeriod <= count_r;
            locked <= 1'b1;
         end
         if (phase_r + 32'h1 >= halfPeriod) begin
            phase_r <= 32'h0;
            halfTick <= 1'b1;
         end else begin
            phase_r <= phase_r + 32'h1;
         end
      end
   end
endmodule

// ---- fbsc_flyback_ctrl.v ----
// Startup sequencer, gate pulse timing and output voltage estimation.
// Assumes all pins and configuration inputs are synchronous to core_clk.
`timescale 1ns/10ps
`include "fbsc_map.vh"
module fbsc_flyback_ctrl (
   input wire core_clk,
   input wire sys_rst,
   input wire clkEn,
   input wire inputVoltageOk,
   input wire chipTempOk,
   input wire protectionFault,
   input wire csAboveLimit,
   input wire auxSensePin,
   input wire [11:0] senseVoltageMv,
   input wire lineSensePin,
   input wire burstMode,
   input wire firstValleyMode,
   input wire discontinuousMode,
   input wire [11:0] chargingCurrentLimit,
   input wire [11:0] prestartCurrentLimit,
   input wire [3:0] softStartSteps,
   input wire [15:0] supplyCapSetting,
   input wire [31:0] maxOnTimeCyc,
   input wire [15:0] chargingSetpointMv,
   input wire [15:0] startupUvLevelMv,
   input wire [7:0] dividerRatioQ4,
   input wire [7:0] turnsRatioQ4,
   input wire [7:0] crossingDelayTrim,
   input wire [7:0] gateSourceCurrentMa,
   output reg gateDriveOut,
   output reg [11:0] currentLimit,
   output reg [7:0] gateSourceCurrent,
   output reg [15:0] outputVoltageMv,
   output reg [2:0] startupState,
   output reg startupUvFault,
   output reg regulatedMode,
   output reg lineLocked
);
   localparam [2:0] ST_PROBE = 3'h0;
   localparam [2:0] ST_WAIT = 3'h1;
   localparam [2:0] ST_SOFT = 3'h2;
   localparam [2:0] ST_CHARGE = 3'h3;
   localparam [2:0] ST_REG = 3'h4;

   // Clamps a configured value between two bounds.
   function [7:0] clampMa;
      input [7:0] v;
      begin
         if (v < `FBSC_GATE_MA_MIN)
            clampMa = `FBSC_GATE_MA_MIN;
         else if (v > `FBSC_GATE_MA_MAX)
            clampMa = `FBSC_GATE_MA_MAX;
         else
            clampMa = v;
      end
   endfunction

   reg [2:0] state_r;
   reg [2:0] state_nxt;
   reg [3:0] step_r;
   reg [11:0] stepSize_r;
   reg [31:0] onCnt_r;
   reg [31:0] swCnt_r;
   reg [31:0] ringPeriod_r;
   reg [31:0] ringCnt_r;
   reg ringMeasure_r;
   reg [2:0] halfCnt_r;
   reg [31:0] sampleCnt_r;
   reg sampleDue_r;
   reg auxDly_r;
   reg [11:0] heldMv_r;
   reg probeDone_r;
   reg restartLoad;
   reg stepLoad;
   reg timeoutLoad;
   wire restartDone;
   wire stepDone;
   wire timeoutDone;
   wire timeoutRun;
   wire [31:0] halfPeriod;
   wire locked;
   wire halfTick;
   wire auxFall = auxDly_r & ~auxSensePin;
   wire blanked = onCnt_r < `FBSC_LEB_CYC;
   wire csTrip = csAboveLimit & ~blanked;
   wire [31:0] estRaw = senseVoltageMv * dividerRatioQ4 * turnsRatioQ4;
   wire [31:0] estShift = estRaw >> 8;
   wire [15:0] estMv = (estShift > `FBSC_DIODE_MV) ?
      estShift[15:0] - 16'd`FBSC_DIODE_MV : 16'h0;

   fbsc_timer restartTimer (
      .core_clk(core_clk), .sys_rst(sys_rst), .clkEn(clkEn),
      .load(restartLoad), .loadValue(`FBSC_RESTART_CYC),
      .running(), .expired(restartDone)
   );
   fbsc_timer stepTimer (
      .core_clk(core_clk), .sys_rst(sys_rst), .clkEn(clkEn),
      .load(stepLoad), .loadValue(`FBSC_STEP_CYC),
      .running(), .expired(stepDone)
   );
   // Timeout counted in cycles from the capacitance setting.
   fbsc_timer timeoutTimer (
      .core_clk(core_clk), .sys_rst(sys_rst), .clkEn(clkEn),
      .load(timeoutLoad),
      .loadValue(supplyCapSetting * `FBSC_TIMEOUT_MULT),
      .running(timeoutRun), .expired(timeoutDone)
   );
   fbsc_half_period halfGen (
      .core_clk(core_clk), .sys_rst(sys_rst), .clkEn(clkEn),
      .lineZero(lineSensePin),
      .allowSync(~burstMode & (firstValleyMode | discontinuousMode) & (state_r == ST_REG)),
      .halfPeriod(halfPeriod), .locked(locked), .halfTick(halfTick)
   );

   ////////////////////////////////////////////////////////////////////////
   // Startup sequencer.
   always @* begin
      state_nxt = state_r;
      restartLoad = 1'b0;
      stepLoad = 1'b0;
      timeoutLoad = 1'b0;
      case (state_r)
         ST_PROBE: begin
            if (probeDone_r) begin
               if (inputVoltageOk && chipTempOk && !protectionFault) begin
                  state_nxt = ST_SOFT;
                  stepLoad = 1'b1;
                  timeoutLoad = 1'b1;
               end else begin
                  state_nxt = ST_WAIT;
                  restartLoad = 1'b1;
               end
            end
         end
         ST_WAIT: begin
            if (restartDone)
               state_nxt = ST_PROBE;
         end
         ST_SOFT: begin
            if (protectionFault) begin
               state_nxt = ST_WAIT;
               restartLoad = 1'b1;
            end else if (stepDone) begin
               if (step_r >= softStartSteps)
                  state_nxt = ST_CHARGE;
               else
                  stepLoad = 1'b1;
            end
         end
         ST_CHARGE: begin
            if (protectionFault) begin
               state_nxt = ST_WAIT;
               restartLoad = 1'b1;
            end else if (timeoutRun && outputVoltageMv >= chargingSetpointMv) begin
               state_nxt = ST_REG;
            end else if (timeoutDone || !timeoutRun) begin
               if (outputVoltageMv >= startupUvLevelMv) begin
                  state_nxt = ST_REG;
               end else begin
                  state_nxt = ST_WAIT;
                  restartLoad = 1'b1;
               end
            end
         end
         ST_REG: begin
            if (protectionFault) begin
               state_nxt = ST_WAIT;
               restartLoad = 1'b1;
            end
         end
         default: state_nxt = ST_PROBE;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   // Gate pulses, current limit and sampling.
   always @(posedge core_clk) begin
      if (sys_rst) begin
         state_r <= ST_PROBE;
         step_r <= 4'h0;
         stepSize_r <= 12'h0;
         onCnt_r <= 32'h0;
         swCnt_r <= 32'h0;
         ringPeriod_r <= 32'h0;
         ringCnt_r <= 32'h0;
         ringMeasure_r <= 1'b1;
         halfCnt_r <= 3'h0;
         sampleCnt_r <= 32'h0;
         sampleDue_r <= 1'b0;
         auxDly_r <= 1'b0;
         heldMv_r <= 12'h0;
         probeDone_r <= 1'b0;
         gateDriveOut <= 1'b0;
         currentLimit <= 12'h0;
         gateSourceCurrent <= `FBSC_GATE_MA_MIN;
         outputVoltageMv <= 16'h0;
         startupState <= ST_PROBE;
         startupUvFault <= 1'b0;
         regulatedMode <= 1'b0;
         lineLocked <= 1'b0;
      end else if (clkEn) begin
         state_r <= state_nxt;
         startupState <= state_nxt;
         regulatedMode <= (state_nxt == ST_REG);
         lineLocked <= locked;
         auxDly_r <= auxSensePin;
         gateSourceCurrent <= clampMa(gateSourceCurrentMa);
         startupUvFault <= (state_r == ST_CHARGE) && (state_nxt == ST_WAIT) &&
            !protectionFault;
         stepSize_r <= chargingCurrentLimit / ({8'h0, softStartSteps} + 12'h1);
         if (state_r != ST_PROBE)
            probeDone_r <= 1'b0;
         swCnt_r <= swCnt_r + 32'h1;
         if (gateDriveOut)
            onCnt_r <= onCnt_r + 32'h1;
         case (state_r)
            ST_PROBE: begin
               currentLimit <= prestartCurrentLimit;
               step_r <= 4'h0;
               ringMeasure_r <= 1'b1;
               if (!gateDriveOut && !probeDone_r && onCnt_r == 32'h0) begin
                  gateDriveOut <= 1'b1;
               end else if (gateDriveOut &&
                  (csTrip || onCnt_r + 32'h1 >= `FBSC_PROBE_LEBS * `FBSC_LEB_CYC)) begin
                  gateDriveOut <= 1'b0;
                  probeDone_r <= 1'b1;
               end
            end
            ST_SOFT: begin
               currentLimit <= stepSize_r * ({8'h0, step_r} + 12'h1);
               if (stepDone)
                  step_r <= step_r + 4'h1;
               if (swCnt_r + 32'h1 >= `FBSC_SS_PERIOD_CYC) begin
                  swCnt_r <= 32'h0;
                  gateDriveOut <= 1'b1;
                  onCnt_r <= 32'h0;
               end else if (gateDriveOut && csTrip) begin
                  gateDriveOut <= 1'b0;
               end
            end
            ST_CHARGE, ST_REG: begin
               currentLimit <= chargingCurrentLimit;
               // First-valley restart on the aux falling crossing.
               if (!gateDriveOut && auxFall) begin
                  gateDriveOut <= 1'b1;
                  onCnt_r <= 32'h0;
               end else if (gateDriveOut && (csTrip || onCnt_r >= maxOnTimeCyc)) begin
                  gateDriveOut <= 1'b0;
               end
            end
            default: begin
               gateDriveOut <= 1'b0;
               onCnt_r <= 32'h0;
            end
         endcase
         // Ringing period from gate off to first aux crossing.
         if (gateDriveOut)
            ringCnt_r <= 32'h0;
         else
            ringCnt_r <= ringCnt_r + 32'h1;
         if (ringMeasure_r && !gateDriveOut && auxFall) begin
            ringPeriod_r <= ringCnt_r;
            ringMeasure_r <= (state_r == ST_PROBE);
         end
         if (halfTick && state_r == ST_REG) begin
            if (halfCnt_r + 3'h1 >= `FBSC_RING_EVERY) begin
               halfCnt_r <= 3'h0;
               ringMeasure_r <= 1'b1;
            end else begin
               halfCnt_r <= halfCnt_r + 3'h1;
            end
         end
         // Quarter ring before crossing, shifted by trim.
         if (sampleDue_r && !gateDriveOut && !burstMode &&
            ringCnt_r + (ringPeriod_r >> 2) + {24'h0, crossingDelayTrim} ==
            ringPeriod_r) begin
            heldMv_r <= senseVoltageMv;
            outputVoltageMv <= estMv;
            sampleDue_r <= 1'b0;
         end
         // Sample spacing of a sixty-fourth half-period; a new request wins over the clear.
         if (sampleCnt_r >= (halfPeriod >> `FBSC_SAMPLE_DIV_SHIFT)) begin
            sampleCnt_r <= 32'h0;
            sampleDue_r <= 1'b1;
         end else begin
            sampleCnt_r <= sampleCnt_r + 32'h1;
         end
         if (burstMode) begin
            outputVoltageMv <= 16'h0;
            sampleDue_r <= 1'b0;
         end
      end
   end
endmodule

// ---- fbsc_ctrl_chk_assertions.sv ----
// Concurrent checks on the flyback startup controller ports.
// Bound to the controller; one clock, synchronous active-high reset.
`timescale 1ns/10ps
module fbsc_ctrl_chk (
   input wire core_clk,
   input wire sys_rst,
   input wire inputVoltageOk,
   input wire chipTempOk,
   input wire burstMode,
   input wire [11:0] chargingCurrentLimit,
   input wire gateDriveOut,
   input wire [11:0] currentLimit,
   input wire [7:0] gateSourceCurrent,
   input wire [15:0] outputVoltageMv,
   input wire [2:0] startupState,
   input wire startupUvFault,
   input wire regulatedMode
);
   reg gPrev_r;
   reg softRise_r;
   reg [31:0] onCnt_r;
   reg [31:0] gap_r;
   wire gateRise = gateDriveOut && !gPrev_r;
   default clocking @(posedge core_clk); endclocking
   default disable iff (sys_rst);
   // Width of the running pulse and spacing of gate rising edges.
   always @(posedge core_clk) begin
      gPrev_r <= gateDriveOut;
      onCnt_r <= gateDriveOut ? onCnt_r + 32'h1 : 32'h0;
      gap_r <= gateRise ? 32'h1 : gap_r + 32'h1;
      softRise_r <= !sys_rst && (gateRise ? startupState == 3'h2 : softRise_r);
   end
   a_probe_end: assert property (
      $rose(gateDriveOut) && startupState == 3'h0 |-> ##[1:192] !gateDriveOut
   ) else $error("probe pulse too long");
   a_probe_start: assert property (
      $fell(sys_rst) |-> ##[0:2] gateDriveOut
   ) else $error("no probe pulse after reset");
   a_blank_hold: assert property (
      $fell(gateDriveOut) |-> onCnt_r >= 32'h18
   ) else $error("pulse ended inside blanking");
   a_soft_period: assert property (
      gateRise && startupState == 3'h2 && softRise_r |-> gap_r == 32'h9C4
   ) else $error("soft start period wrong");
   a_charge_limit: assert property (
      startupState == 3'h3 [*2] |-> currentLimit == chargingCurrentLimit
   ) else $error("charging limit wrong");
   a_no_start: assert property (
      startupState == 3'h0 && !(inputVoltageOk && chipTempOk) |=> startupState != 3'h2
   ) else $error("started with failed checks");
   a_uv_restart: assert property (
      startupUvFault |-> ##[0:2] startupState == 3'h1 && !regulatedMode
   ) else $error("no restart after undervoltage");
   a_uv_pulse: assert property (
      startupUvFault |=> !startupUvFault
   ) else $error("undervoltage flag not a pulse");
   a_reg_state: assert property (
      regulatedMode |-> startupState == 3'h4
   ) else $error("regulated flag without state");
   a_gate_range: assert property (
      gateSourceCurrent >= 8'h1E && gateSourceCurrent <= 8'hB4
   ) else $error("gate current out of range");
   a_burst_est: assert property (
      burstMode [*3] |-> outputVoltageMv == 16'h0
   ) else $error("estimate live in burst");
endmodule

// ---- fbsc_power_stage.sv ----
// Power stage model: shunt current ramp, aux demagnetisation and ringing.
// Assumes the gate output is registered on core_clk.
`timescale 1ns/10ps
module fbsc_power_stage (
   input wire core_clk,
   input wire gateDriveOut,
   input wire [11:0] currentLimit,
   input wire [7:0] rampSlope,
   input wire [11:0] reflectMv,
   output reg csAboveLimit = 1'b0,
   output reg auxSensePin = 1'b0,
   output reg [11:0] senseVoltageMv = 12'h0
);
   reg [15:0] onCnt_r = 16'h0;
   reg [15:0] offCnt_r = 16'hFFFF;
   wire demag = !gateDriveOut && offCnt_r < 16'h12C;
   always @(posedge core_clk) begin
      onCnt_r <= gateDriveOut ? onCnt_r + 16'h1 : 16'h0;
      offCnt_r <= gateDriveOut ? 16'h0 : offCnt_r + {15'h0, offCnt_r != 16'hFFFF};
      csAboveLimit <= gateDriveOut && (onCnt_r + 16'h1) * rampSlope >= currentLimit;
      // Demagnetisation, then eight ringing half-cycles of 16 clocks.
      auxSensePin <= demag || (!gateDriveOut && offCnt_r < 16'h1AC && offCnt_r[4]);
      // Outside demagnetisation the pin does not show the reflected output.
      senseVoltageMv <= demag ? reflectMv : ~reflectMv;
   end
endmodule

// ---- fbsc_flyback_ctrl_tb.sv ----
// Self-checking bench for the flyback startup controller.
// Assumes the power stage model and the port checker beside it.
`timescale 1ns/10ps
module fbsc_flyback_ctrl_tb;
   logic core_clk = 1'b0, sys_rst = 1'b1, clkEn = 1'b1;
   logic inputVoltageOk = 1'b1, chipTempOk = 1'b1, protectionFault = 1'b0;
   logic lineSensePin = 1'b0, burstMode = 1'b0, firstValleyMode = 1'b1;
   logic discontinuousMode = 1'b0;
   logic [11:0] chargingCurrentLimit = 12'h600, prestartCurrentLimit = 12'h100;
   logic [11:0] reflectMv = 12'h1F4;
   logic [3:0] softStartSteps = 4'h1;
   logic [15:0] supplyCapSetting = 16'h37, chargingSetpointMv = 16'h1B58;
   logic [15:0] startupUvLevelMv = 16'hBB8;
   logic [31:0] maxOnTimeCyc = 32'h3E8;
   logic [7:0] dividerRatioQ4 = 8'h40, turnsRatioQ4 = 8'h20, crossingDelayTrim = 8'h00;
   logic [7:0] gateSourceCurrentMa = 8'h05, rampSlope = 8'h01;
   wire csAboveLimit, auxSensePin, gateDriveOut, startupUvFault, regulatedMode, lineLocked;
   wire [11:0] senseVoltageMv, currentLimit;
   wire [7:0] gateSourceCurrent;
   wire [15:0] outputVoltageMv;
   wire [2:0] startupState;
   int n_fail = 0, total_checks = 0, cyc = 0;
   fbsc_flyback_ctrl i_dut (.*);
   fbsc_power_stage i_stage (.*);
   always #10 core_clk = ~core_clk;
   always @(posedge core_clk) begin
      cyc++;
      if (cyc == 100000) begin
         n_fail++;
         tally_and_finish();
      end
   end
   task automatic tally_and_finish();
      if (n_fail == 0 && total_checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("[FAIL] %0t seen %0h expected %0h", $time, seen, exp);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge core_clk);
   endtask
   task automatic do_reset();
      @(posedge core_clk);
      sys_rst <= 1'b1;
      tick(10);
      sys_rst <= 1'b0;
   endtask
   task automatic wait_state(input logic [2:0] s, input int lim);
      for (int i = 0; i < lim && startupState !== s; i++) @(posedge core_clk);
      tick(3);
   endtask
   // Waits for a gate pulse and returns its width in clocks.
   task automatic pulse_width(output int w);
      w = 0;
      for (int i = 0; i < 5000 && gateDriveOut !== 1'b1; i++) @(posedge core_clk);
      while (gateDriveOut === 1'b1 && w < 5000) begin
         w++;
         @(posedge core_clk);
      end
   endtask
   task automatic t_probe_fail();
      int w;
      chipTempOk <= 1'b0;
      do_reset();
      check(gateSourceCurrent, 8'h1E);
      pulse_width(w);
      check(w, 192);
      tick(5);
      check(startupState, 3'h1);
      check(regulatedMode, 1'b0);
   endtask
   task automatic t_probe_blank();
      int w;
      chipTempOk <= 1'b1;
      inputVoltageOk <= 1'b0;
      rampSlope <= 8'h10;
      gateSourceCurrentMa <= 8'hFF;
      do_reset();
      pulse_width(w);
      check(w >= 24 && w <= 26, 1);
      check(gateSourceCurrent, 8'hB4);
      tick(5);
      check(startupState, 3'h1);
   endtask
   task automatic t_normal();
      int w;
      int l;
      inputVoltageOk <= 1'b1;
      gateSourceCurrentMa <= 8'h64;
      do_reset();
      wait_state(3'h2, 1000);
      check(currentLimit, 12'h300);
      check(gateSourceCurrent, 8'h64);
      pulse_width(w);
      for (l = 0; l < 5000 && gateDriveOut !== 1'b1; l++) @(posedge core_clk);
      check(w + l, 2500);
      tick(25000);
      check(currentLimit, 12'h600);
      wait_state(3'h3, 30000);
      check(currentLimit, chargingCurrentLimit);
      check(outputVoltageMv, 16'hCE4);
      wait_state(3'h4, 20000);
      check(regulatedMode, 1'b1);
      lineSensePin <= 1'b1;
      tick(4);
      check(lineLocked, 1'b1);
      burstMode <= 1'b1;
      tick(10);
      check(outputVoltageMv, 16'h0);
      check(lineLocked, 1'b0);
      burstMode <= 1'b0;
      lineSensePin <= 1'b0;
   endtask
   task automatic t_uv();
      int n;
      softStartSteps <= 4'h0;
      supplyCapSetting <= 16'h1E;
      reflectMv <= 12'h12C;
      do_reset();
      wait_state(3'h2, 1000);
      check(currentLimit, 12'h600);
      for (n = 3; n < 40000 && startupUvFault !== 1'b1; n++) @(posedge core_clk);
      check(n >= 29005 && n <= 29015, 1);
      tick(3);
      check(startupState, 3'h1);
      check(regulatedMode, 1'b0);
   endtask
   initial begin
      t_probe_fail();
      t_probe_blank();
      t_normal();
      t_uv();
      tally_and_finish();
   end
endmodule
bind fbsc_flyback_ctrl fbsc_ctrl_chk i_chk (.*);
